// ### design/pwm_clock_divider.sv
// pwm clock enable divider with boundary-aligned ratio change
`timescale 1ns/1ps
`include "sleep_gating_reset_cause_ctl_map.svh"
module pwm_clock_divider (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_soft_rst,
  input  wire logic [2:0] i_sel,
  output logic      [2:0] o_applied_sel,
  output logic            o_applied,
  output logic            o_tick
);
  logic [5:0] cnt;
  logic [5:0] limit;

  assign limit = 6'((7'h01 << o_applied_sel) - 7'h01);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // a new ratio is only taken when the count wraps, so no short period
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt           <= 6'h00;
      o_applied_sel <= `SC_PWM_DIV_BY_1;
      o_applied     <= 1'b0;
      o_tick        <= 1'b0;
    end else if (i_soft_rst) begin
      cnt           <= 6'h00;
      o_applied_sel <= `SC_PWM_DIV_BY_1;
      o_applied     <= 1'b0;
      o_tick        <= 1'b0;
    end else if (cnt == limit) begin
      cnt           <= 6'h00;
      o_tick        <= 1'b1;
      o_applied_sel <= i_sel;
      o_applied     <= (i_sel != o_applied_sel);
    end else begin
      cnt       <= 6'(cnt + 6'h01);
      o_tick    <= 1'b0;
      o_applied <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  div_boundary_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!$past(i_soft_rst) && o_applied_sel != $past(o_applied_sel)) |-> $past(cnt) == $past(limit))
    else $error("divider ratio changed away from a period boundary");

  tick_spacing_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst || i_soft_rst)
    (o_tick && o_applied_sel == 3'h1 && $stable(o_applied_sel)) |=> !o_tick ##1 o_tick)
    else $error("divide by two tick not every second cycle");
endmodule

// ### design/sleep_gating_reset_cause_ctl.sv
// system control: sleep clock gating, pwm clock divider, reset cause record, capability info
`timescale 1ns/1ps
`include "sleep_gating_reset_cause_ctl_map.svh"
module sleep_gating_reset_cause_ctl #(
  parameter logic [`SC_N_PIN-1:0] PIN_PRESENT = 33'h1_FFFF_FFFF,
  parameter logic [31:0]          SRAM_BYTES  = 32'h0000_2000
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [7:0]               i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic                          o_pready,
  output logic      [31:0]              o_prdata,
  output logic                          o_pslverr,
  input  wire logic                     i_sleep_req,
  input  wire logic [`SC_N_PERIPH-1:0]  i_wake,
  input  wire logic                     i_wdog_reset,
  input  wire logic                     i_bor_reset,
  input  wire logic                     i_ext_reset,
  output logic      [`SC_N_PERIPH-1:0]  o_periph_clk_en,
  output logic                          o_cpu_halt,
  output logic                          o_sys_reset,
  output logic                          o_pwm_clk_en,
  output logic                          o_irq
);
  localparam int NP = `SC_N_PERIPH;
  localparam int ND = `SC_RUN_EN_DELAY;

  sleep_gating_reset_cause_ctl_pkg::pm_state_t pm_state;

  logic [NP-1:0]            run_en;
  logic [NP-1:0]            run_stage [ND];
  logic [NP-1:0]            run_eff;
  logic [NP-1:0]            sleep_en;
  logic [NP-1:0]            sleep_mask;
  logic                     auto_gate;
  logic [2:0]               pwm_sel;
  logic [2:0]               pwm_applied_sel;
  logic                     pwm_applied;
  logic [`SC_N_CAUSE-1:0]   cause_rec;
  logic [`SC_N_CAUSE-1:0]   cause_set;
  logic [`SC_N_INT-1:0]     int_stat;
  logic [`SC_N_INT-1:0]     int_mask;
  logic [`SC_N_INT-1:0]     int_evt;
  logic [2:0]               pin_s1;
  logic [2:0]               pin_s2;
  logic [2:0]               pin_s3;
  logic                     wdog_evt;
  logic                     bor_evt;
  logic                     ext_evt;
  logic                     sw_req;
  logic                     dev_rst;
  logic [3:0]               rst_cnt;
  logic                     wake_hit;
  logic                     pending;
  logic                     pending_d;
  logic                     acc;
  logic                     wr;
  logic                     rd_setup;
  logic [31:0]              rd_mux;
  logic                     rd_hit;

  // ----------------------------------------------------------------
  // reset pin synchronisers
  // ----------------------------------------------------------------
  // the third stage only feeds the edge detect; stage one is read by stage two alone
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
    end else begin
      pin_s1 <= {i_ext_reset, i_bor_reset, i_wdog_reset};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign wdog_evt = pin_s2[0] & ~pin_s3[0];
  assign bor_evt  = pin_s2[1] & ~pin_s3[1];
  assign ext_evt  = pin_s2[2] & ~pin_s3[2];

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  // one wait state so that read data and pready both leave flip-flops
  assign acc      = i_psel & i_penable & o_pready;
  assign wr       = acc & i_pwrite;
  assign rd_setup = i_psel & i_penable & ~o_pready & ~i_pwrite;
  assign sw_req   = wr && i_paddr == `SC_OFF_SW_RESET && i_pwdata[0];
  assign dev_rst  = sw_req | wdog_evt | bor_evt | ext_evt;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_paddr)
      `SC_OFF_PIN_LO:   rd_mux = PIN_PRESENT[31:0];
      `SC_OFF_PIN_HI:   rd_mux = {31'h0000_0000, PIN_PRESENT[32]};
      `SC_OFF_SRAM:     rd_mux = SRAM_BYTES;
      `SC_OFF_RUN_EN:   rd_mux = {8'h00, run_en};
      `SC_OFF_SLEEP_EN: rd_mux = {8'h00, sleep_en};
      `SC_OFF_GATE:     rd_mux = {31'h0000_0000, auto_gate};
      `SC_OFF_PWM_DIV:  rd_mux = {29'h0000_0000, pwm_sel};
      `SC_OFF_CAUSE:    rd_mux = {27'h0000_000, cause_rec};
      `SC_OFF_SW_RESET: rd_mux = 32'h0000_0000;
      `SC_OFF_STATUS:   rd_mux = {29'h0000_0000, pwm_applied_sel != pwm_sel, pending,
                                  pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep};
      `SC_OFF_INT_STAT: rd_mux = {29'h0000_0000, int_stat};
      `SC_OFF_INT_MASK: rd_mux = {29'h0000_0000, int_mask};
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_prdata  <= rd_setup ? rd_mux : 32'h0000_0000;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // any device reset returns these to defaults; the cause record is kept apart
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      run_en    <= '0;
      sleep_en  <= '0;
      auto_gate <= 1'b0;
      pwm_sel   <= `SC_PWM_DIV_BY_1;
      int_mask  <= '0;
    end else if (dev_rst) begin
      run_en    <= '0;
      sleep_en  <= '0;
      auto_gate <= 1'b0;
      pwm_sel   <= `SC_PWM_DIV_BY_1;
      int_mask  <= '0;
    end else if (wr && !o_sys_reset) begin
      case (i_paddr)
        `SC_OFF_RUN_EN:   run_en    <= i_pwdata[NP-1:0];
        `SC_OFF_SLEEP_EN: sleep_en  <= i_pwdata[NP-1:0];
        `SC_OFF_GATE:     auto_gate <= i_pwdata[0];
        `SC_OFF_PWM_DIV: begin
          if (i_pwdata[2:0] <= `SC_PWM_DIV_BY_64) begin
            pwm_sel <= i_pwdata[2:0];
          end
        end
        `SC_OFF_INT_MASK: int_mask <= i_pwdata[`SC_N_INT-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // enable settling pipeline
  // ----------------------------------------------------------------
  // peripherals see a written enable only after the settling delay
  genvar g;
  generate
    for (g = 0; g < ND; g++) begin : g_stage
      always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
          run_stage[g] <= '0;
        end else if (dev_rst) begin
          run_stage[g] <= '0;
        end else begin
          run_stage[g] <= (g == 0) ? run_en : run_stage[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign run_eff = run_stage[ND-1];
  assign pending = run_eff != run_en;

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  // gating off means every enabled peripheral keeps running and may wake
  assign sleep_mask = auto_gate ? sleep_en : '1;
  assign wake_hit   = |(i_wake & run_eff & sleep_mask);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pm_state <= sleep_gating_reset_cause_ctl_pkg::st_run;
    end else if (dev_rst) begin
      pm_state <= sleep_gating_reset_cause_ctl_pkg::st_run;
    end else begin
      case (pm_state)
        sleep_gating_reset_cause_ctl_pkg::st_run: begin
          if (i_sleep_req && !wake_hit) begin
            pm_state <= sleep_gating_reset_cause_ctl_pkg::st_sleep;
          end
        end
        sleep_gating_reset_cause_ctl_pkg::st_sleep: begin
          if (wake_hit) begin
            pm_state <= sleep_gating_reset_cause_ctl_pkg::st_run;
          end
        end
        default: pm_state <= sleep_gating_reset_cause_ctl_pkg::st_run;
      endcase
    end
  end

  // clocks are only enabled, never reset, so a stopped peripheral keeps its state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_periph_clk_en <= '0;
      o_cpu_halt      <= 1'b0;
    end else begin
      if (pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep) begin
        o_periph_clk_en <= run_eff & sleep_mask;
      end else begin
        o_periph_clk_en <= run_eff;
      end
      o_cpu_halt <= pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep;
    end
  end

  // ----------------------------------------------------------------
  // device reset pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt     <= 4'h0;
      o_sys_reset <= 1'b0;
    end else if (dev_rst) begin
      rst_cnt     <= 4'(`SC_SYS_RST_CYC - 1);
      o_sys_reset <= 1'b1;
    end else begin
      rst_cnt     <= (rst_cnt != 4'h0) ? 4'(rst_cnt - 4'h1) : 4'h0;
      o_sys_reset <= rst_cnt != 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // reset cause record
  // ----------------------------------------------------------------
  // power-up marks the power-on bit; a set in the clearing cycle wins
  always_comb begin
    cause_set                  = '0;
    cause_set[`SC_CAUSE_SW]    = sw_req;
    cause_set[`SC_CAUSE_WDOG]  = wdog_evt;
    cause_set[`SC_CAUSE_BOR]   = bor_evt;
    cause_set[`SC_CAUSE_EXT]   = ext_evt;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cause_rec <= `SC_CAUSE_RESET;
    end else if (ext_evt) begin
      cause_rec <= cause_set;
    end else if (wr && i_paddr == `SC_OFF_CAUSE) begin
      cause_rec <= (cause_rec & ~i_pwdata[`SC_N_CAUSE-1:0]) | cause_set;
    end else begin
      cause_rec <= cause_rec | cause_set;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_d <= 1'b0;
    end else begin
      pending_d <= pending;
    end
  end

  always_comb begin
    int_evt                  = '0;
    int_evt[`SC_INT_WAKE]    = pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep
                               && wake_hit;
    int_evt[`SC_INT_DIV]     = pwm_applied;
    int_evt[`SC_INT_SETTLED] = pending_d & ~pending;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      int_stat <= '0;
      o_irq    <= 1'b0;
    end else if (dev_rst) begin
      int_stat <= '0;
      o_irq    <= 1'b0;
    end else begin
      if (wr && i_paddr == `SC_OFF_INT_STAT) begin
        int_stat <= (int_stat & ~i_pwdata[`SC_N_INT-1:0]) | int_evt;
      end else begin
        int_stat <= int_stat | int_evt;
      end
      o_irq <= |(int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // pwm clock
  // ----------------------------------------------------------------
  pwm_clock_divider u_pwm_div (
    .i_sys_clk     (i_sys_clk),
    .i_rst         (i_rst),
    .i_soft_rst    (dev_rst),
    .i_sel         (pwm_sel),
    .o_applied_sel (pwm_applied_sel),
    .o_applied     (pwm_applied),
    .o_tick        (o_pwm_clk_en)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wake_up;
    pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep
    ##1 pm_state == sleep_gating_reset_cause_ctl_pkg::st_run;
  endsequence

  sequence s_enable_write;
    (wr && i_paddr == `SC_OFF_RUN_EN) ##1 (!wr && !dev_rst)[*5];
  endsequence

  sleep_gate_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep && auto_gate)
    |=> (o_periph_clk_en & ~$past(sleep_en)) == '0)
    else $error("gated peripheral clocked during sleep");

  wake_resume_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    s_wake_up |=> o_periph_clk_en == $past(run_eff))
    else $error("run enabled peripheral not resumed after wake");

  gate_off_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (!auto_gate && pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep)
    |=> o_periph_clk_en == $past(run_eff))
    else $error("peripheral stopped in sleep with gating off");

  wake_exit_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep && |(i_wake & run_eff & sleep_en))
    |=> pm_state == sleep_gating_reset_cause_ctl_pkg::st_run ##1 !o_cpu_halt)
    else $error("sleep enabled peripheral failed to wake processor");

  halt_hold_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep && !wake_hit && !dev_rst)
    |=> o_cpu_halt && pm_state == sleep_gating_reset_cause_ctl_pkg::st_sleep)
    else $error("processor left sleep without a wake event");

  enable_delay_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    s_enable_write |=> run_eff == $past(run_en))
    else $error("enable not effective five cycles after write");

  sw_cause_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sw_req && !ext_evt) |=> cause_rec[`SC_CAUSE_SW]
    && (cause_rec & $past(cause_rec)) == $past(cause_rec))
    else $error("software reset lost cause bits or software bit");

  cause_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (wr && i_paddr == `SC_OFF_CAUSE && cause_set == '0)
    |=> cause_rec == ($past(cause_rec) & ~$past(i_pwdata[`SC_N_CAUSE-1:0])))
    else $error("cause clear touched the wrong bits");

  sys_reset_len_a: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    sw_req |=> (o_sys_reset && sleep_en == '0 && run_en == '0)[*8] ##1 !o_sys_reset)
    else $error("device reset pulse length or defaults wrong");
endmodule

// ### design/sleep_gating_reset_cause_ctl_map.svh
// register map, field positions, reset values and timing counts of the system control block
//
// Notes on behaviour
// - gating on and sleep enable clear: peripheral clock stops during processor sleep
// - run-enabled peripheral resumes on wake with its state untouched
// - gating off: sleep enables stay stored but are ignored in sleep
// - sleep-enabled peripheral keeps its clock and can wake the processor
// - gating off: every run-enabled peripheral stays clocked during processor sleep
// - processor stays halted in sleep until a wake event
// - pwm clock divides processor clock by 1..64 in powers of two; reads back
// - software reset resets everything and restores defaults except the cause record
// - software reset keeps old cause bits and adds the software bit
// - sticky cause bits for five reset kinds; external reset clears the rest
// - software clears any chosen subset of cause bits, others untouched
// - readable presence bit for each optional pin
// - readable total sram size in bytes
// - peripheral enable takes five cycles after the write
`ifndef SLEEP_GATING_RESET_CAUSE_CTL_MAP_SVH
`define SLEEP_GATING_RESET_CAUSE_CTL_MAP_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SC_N_PERIPH      24
`define SC_N_PIN         33
`define SC_N_CAUSE       5
`define SC_N_INT         3

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SC_OFF_PIN_LO    8'h00
`define SC_OFF_PIN_HI    8'h04
`define SC_OFF_SRAM      8'h08
`define SC_OFF_RUN_EN    8'h0C
`define SC_OFF_SLEEP_EN  8'h10
`define SC_OFF_GATE      8'h14
`define SC_OFF_PWM_DIV   8'h18
`define SC_OFF_CAUSE     8'h1C
`define SC_OFF_SW_RESET  8'h20
`define SC_OFF_STATUS    8'h24
`define SC_OFF_INT_STAT  8'h28
`define SC_OFF_INT_MASK  8'h2C

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define SC_CAUSE_EXT     0
`define SC_CAUSE_POR     1
`define SC_CAUSE_BOR     2
`define SC_CAUSE_WDOG    3
`define SC_CAUSE_SW      4
`define SC_CAUSE_RESET   5'h02
`define SC_INT_WAKE      0
`define SC_INT_DIV       1
`define SC_INT_SETTLED   2
`define SC_STAT_SLEEP    0
`define SC_STAT_PENDING  1
`define SC_PWM_DIV_BY_1  3'h0
`define SC_PWM_DIV_BY_64 3'h6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SC_CLK_MHZ       25
`define SC_RUN_EN_DELAY  5
`define SC_SYS_RST_NS    320
`define SC_SYS_RST_CYC   ((`SC_SYS_RST_NS * `SC_CLK_MHZ + 999) / 1000)

`endif

// ### design/sleep_gating_reset_cause_ctl_pkg.sv
// types shared by the system control block
package sleep_gating_reset_cause_ctl_pkg;
  typedef enum logic {
    st_run,
    st_sleep
  } pm_state_t;
endpackage

// ### tb/tb_sleep_gating_reset_cause_ctl.sv
// self-checking testbench of the system control block
`timescale 1ns/1ps
`include "sleep_gating_reset_cause_ctl_map.svh"
module tb_sleep_gating_reset_cause_ctl;
  // ----------------------------------------------------------------
  // signals and dut
  // ----------------------------------------------------------------
  localparam logic [32:0] PINS = 33'h1_2345_6789;
  localparam logic [31:0] SRAM = 32'h0000_4000;
  logic        clk, rst, psel, penable, pwrite, sleep_req, wdog, bor, ext;
  logic        pready, pslverr, halt, sys_rst, pwm_en, irq, err;
  logic [7:0]  paddr;
  logic [23:0] wake, clk_en;
  logic [31:0] pwdata, prdata, rdata;
  int          fail_count, checked;
  sleep_gating_reset_cause_ctl #(.PIN_PRESENT(PINS), .SRAM_BYTES(SRAM)) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_sleep_req(sleep_req), .i_wake(wake),
    .i_wdog_reset(wdog), .i_bor_reset(bor), .i_ext_reset(ext),
    .o_periph_clk_en(clk_en), .o_cpu_halt(halt), .o_sys_reset(sys_rst),
    .o_pwm_clk_en(pwm_en), .o_irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // request held from setup until pready is sampled high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(k), 32'h2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask
  task automatic wait_halt(input logic lvl);
    int k;
    k = 0;
    while (halt !== lvl && k < 20) begin
      @(posedge clk);
      k++;
    end
    check({31'h0, halt}, {31'h0, lvl});
  endtask
  task automatic go_sleep;
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    wait_halt(1'b1);
  endtask
  // waits for device reset to rise and then fall; checks only that the whole wait stays under 40 cycles
  task automatic wait_rst;
    int k;
    k = 0;
    while (sys_rst !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    while (sys_rst !== 1'b0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    check(32'(k < 40), 32'h1);
  endtask
  task automatic pin_rst(input int which);
    @(posedge clk);
    wdog <= (which == 0);
    bor <= (which == 1);
    ext <= (which == 2);
    repeat (4) @(posedge clk);
    {wdog, bor, ext} <= 3'h0;
    wait_rst();
  endtask
  // the old ratio may still finish its period, so measure pulses two to three
  task automatic pwm_period(input int sel);
    int k, n, first;
    wr(`SC_OFF_PWM_DIV, 32'(sel));
    k = 0;
    n = 0;
    first = 0;
    while (n < 3 && k < 400) begin
      @(posedge clk);
      k++;
      if (pwm_en === 1'b1) begin
        n++;
        if (n == 2) first = k;
      end
    end
    check(32'(k - first), 32'(1 << sel));
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 8000);
    fail_count++;
    $display("ERROR %0t: run did not finish", $time);
    give_verdict();
  end
  initial begin
    int k;
    {rst, psel, penable, pwrite, sleep_req, wdog, bor, ext} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0;
    wake = 24'h0;
    fail_count = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SC_OFF_CAUSE, 32'h2);
    rd_chk(`SC_OFF_PIN_LO, PINS[31:0]);
    rd_chk(`SC_OFF_PIN_HI, {31'h0, PINS[32]});
    rd_chk(`SC_OFF_SRAM, SRAM);
    rd_chk(8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int s = 0; s < 7; s++) begin
      pwm_period(s);
      rd_chk(`SC_OFF_PWM_DIV, 32'(s));
    end
    wr(`SC_OFF_PWM_DIV, 32'h7);
    rd_chk(`SC_OFF_PWM_DIV, 32'h6);
    wr(`SC_OFF_RUN_EN, 32'h00FF_FFFF);
    k = 0;
    while (clk_en !== 24'hFF_FFFF && k < 20) begin
      @(posedge clk);
      k++;
    end
    check(32'(k >= 5 && k <= 7), 32'h1);
    rd_chk(`SC_OFF_STATUS, 32'h0);
    rd_chk(`SC_OFF_INT_STAT, 32'h6);
    wr(`SC_OFF_GATE, 32'h1);
    wr(`SC_OFF_SLEEP_EN, 32'h0000_000F);
    wr(`SC_OFF_INT_MASK, 32'h1);
    go_sleep();
    repeat (2) @(posedge clk);
    check({8'h0, clk_en}, 32'h0000_000F);
    wake <= 24'h00_0100;
    repeat (4) @(posedge clk);
    check({31'h0, halt}, 32'h1);
    wake <= 24'h00_0001;
    wait_halt(1'b0);
    wake <= 24'h0;
    repeat (2) @(posedge clk);
    check({8'h0, clk_en}, 32'h00FF_FFFF);
    check({31'h0, irq}, 32'h1);
    wr(`SC_OFF_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // gating off: sleep enables kept but every peripheral keeps running
    wr(`SC_OFF_GATE, 32'h0);
    go_sleep();
    repeat (2) @(posedge clk);
    check({8'h0, clk_en}, 32'h00FF_FFFF);
    rd_chk(`SC_OFF_SLEEP_EN, 32'h0000_000F);
    rd_chk(`SC_OFF_STATUS, 32'h1);
    wake <= 24'h00_0100;
    wait_halt(1'b0);
    wake <= 24'h0;
    wr(`SC_OFF_CAUSE, 32'h2);
    rd_chk(`SC_OFF_CAUSE, 32'h0);
    pin_rst(0);
    rd_chk(`SC_OFF_CAUSE, 32'h8);
    pin_rst(1);
    rd_chk(`SC_OFF_CAUSE, 32'hC);
    wr(`SC_OFF_CAUSE, 32'h8);
    rd_chk(`SC_OFF_CAUSE, 32'h4);
    wr(`SC_OFF_RUN_EN, 32'h3);
    wr(`SC_OFF_PWM_DIV, 32'h2);
    wr(`SC_OFF_SW_RESET, 32'h1);
    wait_rst();
    rd_chk(`SC_OFF_CAUSE, 32'h14);
    rd_chk(`SC_OFF_RUN_EN, 32'h0);
    rd_chk(`SC_OFF_PWM_DIV, 32'h0);
    check({8'h0, clk_en}, 32'h0);
    pin_rst(2);
    rd_chk(`SC_OFF_CAUSE, 32'h1);
    wr(`SC_OFF_CAUSE, 32'h1F);
    rd_chk(`SC_OFF_CAUSE, 32'h0);
    give_verdict();
  end
endmodule
